// ---- hsps_pkg.sv ----
// Function
// - Start with gate drive off until qualified
// - Both seat detects active low, both required
// - Seat detects held for full insertion delay
// - Insertion delay from two-bit field
// - Bit zero enables seat detect conditions
// - Supply in window for whole insertion delay
// - Master enable needed to start and stay
// - Qualified preconditions turn on switch drive
// - Power good after drain low, gate high
// - Output zero driven out of reset, cascaded enables release the rest from high impedance
// - Listed events shut down switch drive
// - Secondary shutdown ignored until timer expires
// - Fault response latched or cooldown retry
// - Unfiltered supply fault shuts down immediately
// - Filtered supply fault needs sustained condition
// - Separate filter enables for low and high
// - Supply latch keeps off, asserts fault
// - Programmable under-voltage falling threshold steps
// - Hysteresis defaults to one step
package hsps_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_NS = 10;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYC = TICK_NS / CLK_NS;
	localparam int DW = 24;

	// Delays in microseconds
	localparam logic [DW-1:0] INS_US0 = 24'h00_c350;
	localparam logic [DW-1:0] INS_US1 = 24'h01_86a0;
	localparam logic [DW-1:0] INS_US2 = 24'h03_0d40;
	localparam logic [DW-1:0] INS_US3 = 24'h06_1a80;
	localparam logic [DW-1:0] FILT_US1 = 24'h00_000a;
	localparam logic [DW-1:0] FILT_US2 = 24'h00_0064;
	localparam logic [DW-1:0] FILT_US3 = 24'h00_03e8;
	localparam logic [DW-1:0] COOL_US = 24'h26_25a0;
	localparam logic [DW-1:0] FS_STEP_US = 24'h00_2710;
	localparam logic [DW-1:0] ZERO_US = 24'h00_0000;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [3:0] REG_PD_SEQ = 4'h3;
	localparam logic [3:0] REG_FILTER = 4'h4;
	localparam logic [3:0] REG_FS_TIMER = 4'h5;
	localparam logic [3:0] REG_FILT_EN = 4'h6;
	localparam logic [3:0] REG_UV_HYST = 4'h7;
	localparam logic [3:0] REG_INSERT = 4'h9;
	localparam logic [3:0] REG_STATUS = 4'ha;

	localparam logic [7:0] RST_PD_SEQ = 8'h01;
	localparam logic [7:0] RST_FILTER = 8'h00;
	localparam logic [7:0] RST_FS_TIMER = 8'h00;
	localparam logic [7:0] RST_FILT_EN = 8'h00;
	localparam logic [7:0] RST_UV_HYST = 8'h01;
	localparam logic [7:0] RST_INSERT = 8'h00;
	localparam logic [7:0] ZERO8 = 8'h00;

	localparam int PD_EN_BIT = 0;
	localparam int FAULT_LATCH_BIT = 4;
	localparam int SUPPLY_LATCH_BIT = 3;
	localparam int FILT_LO = 1;
	localparam int UV_FILT_EN_BIT = 3;
	localparam int OV_FILT_EN_BIT = 2;
	localparam int INS_LO = 0;
	localparam int FS_LO = 0;
	localparam int HYST_LO = 0;

	typedef enum logic [2:0] {
		ST_OFF,
		ST_QUAL,
		ST_RAMP,
		ST_ON,
		ST_COOL,
		ST_LATCHED
	} hsps_state_t;

	typedef struct packed {
		logic seat_detect_one_n;
		logic seat_detect_two_n;
		logic master_enable_compare;
		logic supply_low_compare;
		logic supply_high_compare;
		logic drain_low_compare;
		logic gate_high_compare;
		logic overcurrent_sense;
		logic secondary_shutdown_n;
	} hsps_sense_t;

endpackage : hsps_pkg

// ---- hsps_sequencer.sv ----
`timescale 1ns/100ps
`default_nettype none
module hsps_sequencer #(
	parameter int TICK_CYCLES = hsps_pkg::TICK_CYC
) (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire hsps_pkg::hsps_sense_t i_sense,
	input wire logic i_good_enable_first,
	input wire logic i_good_enable_second,
	input wire logic i_good_enable_third,
	input wire logic i_cfg_wr,
	input wire logic [3:0] i_cfg_addr,
	input wire logic [7:0] i_cfg_wdata,
	output logic [7:0] o_cfg_rdata,
	output logic o_switch_drive,
	output logic [3:0] o_power_good_outputs_n,
	output logic [3:0] o_power_good_oe,
	output logic o_fault_n,
	output logic [3:0] o_uv_falling_steps
);

	// ****************************************
	// Delay decoding
	// ****************************************
	function automatic logic [hsps_pkg::DW-1:0] hsps_filt_delay(input logic [1:0] code);
		case (code)
			2'h1: hsps_filt_delay = hsps_pkg::FILT_US1;
			2'h2: hsps_filt_delay = hsps_pkg::FILT_US2;
			2'h3: hsps_filt_delay = hsps_pkg::FILT_US3;
			default: hsps_filt_delay = hsps_pkg::ZERO_US;
		endcase
	endfunction : hsps_filt_delay

	function automatic logic [hsps_pkg::DW-1:0] hsps_ins_delay(input logic [1:0] code);
		case (code)
			2'h1: hsps_ins_delay = hsps_pkg::INS_US1;
			2'h2: hsps_ins_delay = hsps_pkg::INS_US2;
			2'h3: hsps_ins_delay = hsps_pkg::INS_US3;
			default: hsps_ins_delay = hsps_pkg::INS_US0;
		endcase
	endfunction : hsps_ins_delay

	// ****************************************
	// Input synchronisers
	// ****************************************
	hsps_pkg::hsps_sense_t sense_meta_reg;
	hsps_pkg::hsps_sense_t sense_reg;

	always_ff @(posedge i_clk_sys) begin
		sense_meta_reg <= i_sense;
		sense_reg <= sense_meta_reg;
	end

	// ****************************************
	// Configuration registers
	// ****************************************
	logic [7:0] pd_seq_reg;
	logic [7:0] filter_reg;
	logic [7:0] fs_timer_reg;
	logic [7:0] filt_en_reg;
	logic [7:0] uv_hyst_reg;
	logic [7:0] insert_reg;
	logic [7:0] status;
	logic [7:0] rdata_next;
	logic [7:0] rdata_reg;

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			pd_seq_reg <= hsps_pkg::RST_PD_SEQ;
			filter_reg <= hsps_pkg::RST_FILTER;
			fs_timer_reg <= hsps_pkg::RST_FS_TIMER;
			filt_en_reg <= hsps_pkg::RST_FILT_EN;
			uv_hyst_reg <= hsps_pkg::RST_UV_HYST;
			insert_reg <= hsps_pkg::RST_INSERT;
		end else if (i_cfg_wr) begin
			case (i_cfg_addr)
				hsps_pkg::REG_PD_SEQ: pd_seq_reg <= i_cfg_wdata;
				hsps_pkg::REG_FILTER: filter_reg <= i_cfg_wdata;
				hsps_pkg::REG_FS_TIMER: fs_timer_reg <= i_cfg_wdata;
				hsps_pkg::REG_FILT_EN: filt_en_reg <= i_cfg_wdata;
				hsps_pkg::REG_UV_HYST: uv_hyst_reg <= i_cfg_wdata;
				hsps_pkg::REG_INSERT: insert_reg <= i_cfg_wdata;
				default: ;
			endcase
		end
	end

	always_comb begin
		case (i_cfg_addr)
			hsps_pkg::REG_PD_SEQ: rdata_next = pd_seq_reg;
			hsps_pkg::REG_FILTER: rdata_next = filter_reg;
			hsps_pkg::REG_FS_TIMER: rdata_next = fs_timer_reg;
			hsps_pkg::REG_FILT_EN: rdata_next = filt_en_reg;
			hsps_pkg::REG_UV_HYST: rdata_next = uv_hyst_reg;
			hsps_pkg::REG_INSERT: rdata_next = insert_reg;
			hsps_pkg::REG_STATUS: rdata_next = status;
			default: rdata_next = hsps_pkg::ZERO8;
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset)
			rdata_reg <= hsps_pkg::ZERO8;
		else
			rdata_reg <= rdata_next;
	end

	assign o_cfg_rdata = rdata_reg;

	// ****************************************
	// Microsecond tick
	// ****************************************
	logic [15:0] tick_cnt_reg;
	logic tick;

	assign tick = (tick_cnt_reg == 16'(TICK_CYCLES - 1));

	always_ff @(posedge i_clk_sys) begin
		if (i_reset || tick)
			tick_cnt_reg <= '0;
		else
			tick_cnt_reg <= tick_cnt_reg + 16'h0001;
	end

	// ****************************************
	// Supply fault filters
	// ****************************************
	logic [1:0] sup_bad;
	logic [1:0] filt_on;
	logic [1:0] sup_fault;
	logic [hsps_pkg::DW-1:0] filt_lim;
	logic [hsps_pkg::DW-1:0] filt_cnt_reg [2];

	assign filt_lim = hsps_filt_delay(filter_reg[hsps_pkg::FILT_LO +: 2]);
	assign sup_bad[0] = !sense_reg.supply_low_compare;
	assign sup_bad[1] = sense_reg.supply_high_compare;
	assign filt_on[0] = filt_en_reg[hsps_pkg::UV_FILT_EN_BIT] && (filt_lim != '0);
	assign filt_on[1] = filt_en_reg[hsps_pkg::OV_FILT_EN_BIT] && (filt_lim != '0);

	always_ff @(posedge i_clk_sys) begin
		for (int i = 0; i < 2; i++) begin
			if (i_reset || !sup_bad[i])
				filt_cnt_reg[i] <= '0;
			else if (tick && filt_cnt_reg[i] < filt_lim)
				filt_cnt_reg[i] <= filt_cnt_reg[i] + 1'b1;
		end
	end

	always_comb begin
		for (int i = 0; i < 2; i++)
			sup_fault[i] = sup_bad[i] && (!filt_on[i] || filt_cnt_reg[i] >= filt_lim);
	end

	// ****************************************
	// Sequencer
	// ****************************************
	hsps_pkg::hsps_state_t state_reg;
	hsps_pkg::hsps_state_t state_next;
	logic [hsps_pkg::DW-1:0] seq_cnt_reg;
	logic [hsps_pkg::DW-1:0] fs_lim;
	logic gate_seen_reg;
	logic seated;
	logic supply_ok;
	logic precond;
	logic removal;
	logic fs_fault;
	logic hard_fault;
	logic supply_hit;
	logic to_latch;

	// Disabled seat detects count as seated
	assign seated = !pd_seq_reg[hsps_pkg::PD_EN_BIT] ||
		(!sense_reg.seat_detect_one_n && !sense_reg.seat_detect_two_n);
	assign supply_ok = sense_reg.supply_low_compare && !sense_reg.supply_high_compare;
	assign precond = seated && supply_ok && sense_reg.master_enable_compare;
	assign removal = !seated || !sense_reg.master_enable_compare;
	assign fs_lim = hsps_pkg::DW'(fs_timer_reg[hsps_pkg::FS_LO +: 3] + 4'h1) * hsps_pkg::FS_STEP_US;
	// Secondary side is unpowered early, so its input waits for the timer
	assign fs_fault = (state_reg == hsps_pkg::ST_ON) && (seq_cnt_reg >= fs_lim) &&
		!sense_reg.secondary_shutdown_n;
	assign supply_hit = |sup_fault;
	assign hard_fault = supply_hit || sense_reg.overcurrent_sense || fs_fault;
	assign to_latch = pd_seq_reg[hsps_pkg::FAULT_LATCH_BIT] ||
		(supply_hit && filter_reg[hsps_pkg::SUPPLY_LATCH_BIT]);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			hsps_pkg::ST_OFF: begin
				if (precond)
					state_next = hsps_pkg::ST_QUAL;
			end
			hsps_pkg::ST_QUAL: begin
				if (!precond)
					state_next = hsps_pkg::ST_OFF;
				else if (seq_cnt_reg >= hsps_ins_delay(insert_reg[hsps_pkg::INS_LO +: 2]))
					state_next = hsps_pkg::ST_RAMP;
			end
			hsps_pkg::ST_RAMP: begin
				if (hard_fault)
					state_next = to_latch ? hsps_pkg::ST_LATCHED : hsps_pkg::ST_COOL;
				else if (removal)
					state_next = hsps_pkg::ST_OFF;
				else if (sense_reg.drain_low_compare &&
					(gate_seen_reg || sense_reg.gate_high_compare))
					state_next = hsps_pkg::ST_ON;
			end
			hsps_pkg::ST_ON: begin
				if (hard_fault || !sense_reg.drain_low_compare)
					state_next = to_latch ? hsps_pkg::ST_LATCHED : hsps_pkg::ST_COOL;
				else if (removal)
					state_next = hsps_pkg::ST_OFF;
			end
			hsps_pkg::ST_COOL: begin
				if (seq_cnt_reg >= hsps_pkg::COOL_US)
					state_next = hsps_pkg::ST_OFF;
			end
			hsps_pkg::ST_LATCHED: begin
				// Dropping the master enable is the way out
				if (!sense_reg.master_enable_compare)
					state_next = hsps_pkg::ST_OFF;
			end
			default: state_next = hsps_pkg::ST_OFF;
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset)
			state_reg <= hsps_pkg::ST_OFF;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset || state_next != state_reg)
			seq_cnt_reg <= '0;
		else if (tick && seq_cnt_reg != '1)
			seq_cnt_reg <= seq_cnt_reg + 1'b1;
	end

	// Gate sense is latched once seen during the ramp
	always_ff @(posedge i_clk_sys) begin
		if (i_reset || state_reg != hsps_pkg::ST_RAMP)
			gate_seen_reg <= 1'b0;
		else if (sense_reg.gate_high_compare)
			gate_seen_reg <= 1'b1;
	end

	// ****************************************
	// Outputs
	// ****************************************
	logic drive_reg;
	logic good_reg;
	logic fault_reg;
	logic [3:0] oe_reg;
	logic [3:0] steps_reg;
	logic drive_next;

	assign drive_next = (state_next == hsps_pkg::ST_RAMP) || (state_next == hsps_pkg::ST_ON);

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			drive_reg <= 1'b0;
			good_reg <= 1'b0;
			fault_reg <= 1'b0;
		end else begin
			drive_reg <= drive_next;
			good_reg <= (state_next == hsps_pkg::ST_ON);
			fault_reg <= (state_next == hsps_pkg::ST_COOL) ||
				(state_next == hsps_pkg::ST_LATCHED);
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			oe_reg <= 4'h0;
		end else begin
			oe_reg[0] <= 1'b1;
			oe_reg[1] <= i_good_enable_first;
			oe_reg[2] <= i_good_enable_first && i_good_enable_second;
			oe_reg[3] <= i_good_enable_first && i_good_enable_second &&
				i_good_enable_third;
		end
	end

	// Comparator applies this falling offset only while supply is good
	always_ff @(posedge i_clk_sys) begin
		if (i_reset)
			steps_reg <= 4'h0;
		else
			steps_reg <= supply_ok ? uv_hyst_reg[hsps_pkg::HYST_LO +: 4] : 4'h0;
	end

	assign status = {1'b0, fault_reg, good_reg, drive_reg, 1'b0, state_reg};
	assign o_switch_drive = drive_reg;
	assign o_power_good_outputs_n = {4{!good_reg}};
	assign o_power_good_oe = oe_reg;
	assign o_fault_n = !fault_reg;
	assign o_uv_falling_steps = steps_reg;

endmodule : hsps_sequencer
`default_nettype wire

// ---- hsps_sequencer_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
module hsps_sequencer_properties #(
	parameter int TICK_CYCLES = 1
) (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire hsps_pkg::hsps_sense_t i_sense,
	input wire logic i_good_enable_first,
	input wire logic i_good_enable_second,
	input wire logic i_good_enable_third,
	input wire logic i_cfg_wr,
	input wire logic [3:0] i_cfg_addr,
	input wire logic [7:0] i_cfg_wdata,
	input wire logic [7:0] o_cfg_rdata,
	input wire logic o_switch_drive,
	input wire logic [3:0] o_power_good_outputs_n,
	input wire logic [3:0] o_power_good_oe,
	input wire logic o_fault_n,
	input wire logic [3:0] o_uv_falling_steps
);
	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);
	logic supply_ok, ready;
	logic [31:0] bad_cnt;
	assign supply_ok = i_sense.supply_low_compare && !i_sense.supply_high_compare;
	assign ready = supply_ok && i_sense.master_enable_compare
		&& !i_sense.seat_detect_one_n && !i_sense.seat_detect_two_n;
	// Bounded by the longest filter, since the checker cannot see the filter setting
	always_ff @(posedge i_clk_sys) begin
		if (i_reset || supply_ok || !o_switch_drive) begin
			bad_cnt <= 32'h0000_0000;
		end else begin
			bad_cnt <= bad_cnt + 32'h0000_0001;
		end
	end
	a_reset_outputs_off: assert property ($fell(i_reset) |-> !o_switch_drive && o_fault_n
		&& o_power_good_outputs_n == 4'hf && o_power_good_oe == 4'h0) else $error("outputs not idle after reset");
	a_drive_after_qualify: assert property ($rose(o_switch_drive) |-> $past(ready, 5)
		&& $past(ready, 8)) else $error("drive rose without qualified preconditions");
	a_master_keeps_on: assert property ((!i_sense.master_enable_compare)[*4] |-> !o_switch_drive)
		else $error("drive on without master enable");
	a_good_needs_drive: assert property (o_power_good_outputs_n != 4'hf |-> o_switch_drive)
		else $error("power good without drive");
	a_good_needs_drain: assert property ($fell(o_power_good_outputs_n[0])
		|-> $past(i_sense.drain_low_compare, 2)) else $error("power good before drain low");
	a_cascade_oe: assert property (o_power_good_oe[3:1] inside {3'h0, 3'h1, 3'h3, 3'h7})
		else $error("power good enables out of cascade");
	a_first_gates_all: assert property ((!i_good_enable_first)[*4] |-> o_power_good_oe[3:1] == 3'h0)
		else $error("outputs driven with first enable low");
	a_fault_blanks_out: assert property (!o_fault_n |-> !o_switch_drive
		&& o_power_good_outputs_n == 4'hf) else $error("fault with outputs on");
	a_supply_cut_bound: assert property (bad_cnt <= 32'(1004 * TICK_CYCLES))
		else $error("supply fault not acted on");
	a_unmapped_zero: assert property (!(i_cfg_addr inside {4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'ha})
		|=> o_cfg_rdata == 8'h00) else $error("unmapped read not zero");
	a_write_readback: assert property (i_cfg_wr && i_cfg_addr == 4'h3 ##1 !i_cfg_wr && i_cfg_addr == 4'h3
		|=> o_cfg_rdata == $past(i_cfg_wdata, 2)) else $error("register readback mismatch");
	a_steps_out_window: assert property ((!supply_ok)[*4] |-> o_uv_falling_steps == 4'h0)
		else $error("hysteresis steps outside window");
	c_drive_on: cover property ($rose(o_switch_drive));
	c_good_on: cover property ($fell(o_power_good_outputs_n[0]));
	c_fault: cover property ($fell(o_fault_n));
endmodule : hsps_sequencer_properties
bind hsps_sequencer hsps_sequencer_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (
	.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_sense(i_sense),
	.i_good_enable_first(i_good_enable_first), .i_good_enable_second(i_good_enable_second),
	.i_good_enable_third(i_good_enable_third), .i_cfg_wr(i_cfg_wr), .i_cfg_addr(i_cfg_addr),
	.i_cfg_wdata(i_cfg_wdata), .o_cfg_rdata(o_cfg_rdata), .o_switch_drive(o_switch_drive),
	.o_power_good_outputs_n(o_power_good_outputs_n), .o_power_good_oe(o_power_good_oe),
	.o_fault_n(o_fault_n), .o_uv_falling_steps(o_uv_falling_steps));
`default_nettype wire

// ---- hsps_card_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module hsps_card_model #(
	parameter int RAMP_CYC = 20
) (
	input wire logic i_clk_sys,
	input wire logic [1:0] i_seated,
	input wire logic i_supply_ok,
	input wire logic i_master_on,
	input wire logic i_switch_drive,
	input wire logic i_secondary_ok,
	output var hsps_pkg::hsps_sense_t o_sense
);
	// ****************************************
	// Card and converter behaviour
	// ****************************************
	int ramp_cnt = 0;
	// Drain and gate settle only after the switch has been driven a while
	always_ff @(posedge i_clk_sys) begin
		ramp_cnt <= i_switch_drive ? ramp_cnt + 1 : 0;
	end
	always_comb begin
		o_sense.seat_detect_one_n = !i_seated[0];
		o_sense.seat_detect_two_n = !i_seated[1];
		o_sense.master_enable_compare = i_master_on;
		o_sense.supply_low_compare = i_supply_ok;
		o_sense.supply_high_compare = !i_supply_ok;
		o_sense.drain_low_compare = ramp_cnt >= RAMP_CYC;
		o_sense.gate_high_compare = ramp_cnt >= RAMP_CYC + 5;
		o_sense.overcurrent_sense = 1'b0;
		// Secondary side feedback is steered by the bench
		o_sense.secondary_shutdown_n = i_secondary_ok;
	end
endmodule : hsps_card_model
`default_nettype wire

// ---- hot_swap_power_sequencer_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module hot_swap_power_sequencer_test;
	logic clk_sys, reset, cfg_wr, supply_ok, master_on, switch_drive, fault_n, secondary_ok;
	logic [1:0] seated;
	logic [2:0] good_en;
	logic [3:0] cfg_addr, pg_n, pg_oe, uv_steps;
	logic [7:0] cfg_wdata, cfg_rdata;
	hsps_pkg::hsps_sense_t sense;
	int num_errors = 0;
	int checks = 0;
	int n;
	logic [3:0] ra[8] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'h2, 4'ha};
	logic [7:0] rv[8] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
	logic [2:0] ge[5] = '{3'h3, 3'h1, 3'h0, 3'h6, 3'h7};
	logic [7:0] oe_exp[5] = '{8'h07, 8'h03, 8'h01, 8'h01, 8'h0f};
	hsps_sequencer #(.TICK_CYCLES(1)) u_dut (.i_clk_sys(clk_sys), .i_reset(reset), .i_sense(sense),
		.i_good_enable_first(good_en[0]), .i_good_enable_second(good_en[1]),
		.i_good_enable_third(good_en[2]), .i_cfg_wr(cfg_wr), .i_cfg_addr(cfg_addr),
		.i_cfg_wdata(cfg_wdata), .o_cfg_rdata(cfg_rdata), .o_switch_drive(switch_drive),
		.o_power_good_outputs_n(pg_n), .o_power_good_oe(pg_oe), .o_fault_n(fault_n),
		.o_uv_falling_steps(uv_steps));
	hsps_card_model #(.RAMP_CYC(20)) u_card (.i_clk_sys(clk_sys), .i_seated(seated),
		.i_supply_ok(supply_ok), .i_master_on(master_on), .i_switch_drive(switch_drive),
		.i_secondary_ok(secondary_ok), .o_sense(sense));
	// ****************************************
	// Tasks
	// ****************************************
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	// Extra cycle keeps the strobe from being reassigned in one time step
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		cfg_addr = a;
		cfg_wdata = d;
		cfg_wr = 1'b1;
		@(negedge clk_sys);
		cfg_wr = 1'b0;
		@(negedge clk_sys);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		cfg_addr = a;
		@(negedge clk_sys);
		cmp(cfg_rdata, exp);
	endtask : rd
	task automatic report_and_stop();
		if (num_errors == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : report_and_stop
	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (80000) @(posedge clk_sys);
		num_errors++;
		report_and_stop();
	end
	initial begin
		reset = 1'b1;
		cfg_wr = 1'b0;
		cfg_addr = 4'h0;
		cfg_wdata = 8'h00;
		seated = 2'h0;
		secondary_ok = 1'b1;
		supply_ok = 1'b0;
		master_on = 1'b0;
		good_en = 3'h0;
		repeat (6) @(posedge clk_sys);
		@(negedge clk_sys);
		reset = 1'b0;
		@(negedge clk_sys);
		cmp({4'h0, pg_oe}, 8'h01);
		for (int i = 0; i < 8; i++) rd(ra[i], rv[i]);
		wr(4'h3, 8'h11);
		wr(4'h2, 8'hff);
		wr(4'ha, 8'hff);
		wr(4'h7, 8'h04);
		rd(4'h3, 8'h11);
		rd(4'h2, 8'h00);
		rd(4'ha, 8'h00);
		rd(4'h7, 8'h04);
		good_en = 3'h7;
		// One seat detect alone must not start qualification
		seated = 2'h1;
		supply_ok = 1'b1;
		master_on = 1'b1;
		repeat (10) @(negedge clk_sys);
		rd(4'ha, 8'h00);
		seated = 2'h3;
		n = 0;
		while (switch_drive !== 1'b1 && n < 60000) begin
			@(negedge clk_sys);
			n++;
		end
		cmp({7'h00, n >= 50000 && n <= 50006}, 8'h01);
		n = 0;
		while (pg_n !== 4'h0 && n < 100) begin
			@(negedge clk_sys);
			n++;
		end
		cmp({4'h0, pg_n}, 8'h00);
		cmp({4'h0, uv_steps}, 8'h04);
		rd(4'ha, 8'h33);
		for (int i = 0; i < 5; i++) begin
			good_en = ge[i];
			repeat (4) @(negedge clk_sys);
			cmp({4'h0, pg_oe}, oe_exp[i]);
		end
		// Secondary side still unpowered, so its low level is ignored
		secondary_ok = 1'b0;
		repeat (4) @(negedge clk_sys);
		secondary_ok = 1'b1;
		cmp({6'h00, switch_drive, fault_n}, 8'h03);
		wr(4'h4, 8'h02);
		wr(4'h6, 8'h0c);
		// Glitch shorter than the filter delay keeps the switch on
		supply_ok = 1'b0;
		repeat (5) @(negedge clk_sys);
		supply_ok = 1'b1;
		repeat (4) @(negedge clk_sys);
		cmp({6'h00, switch_drive, fault_n}, 8'h03);
		wr(4'h6, 8'h00);
		supply_ok = 1'b0;
		repeat (2) @(negedge clk_sys);
		cmp({7'h00, switch_drive}, 8'h01);
		@(negedge clk_sys);
		cmp({2'h0, switch_drive, fault_n, pg_n}, 8'h0f);
		supply_ok = 1'b1;
		repeat (100) @(negedge clk_sys);
		cmp({2'h0, switch_drive, fault_n, pg_n}, 8'h0f);
		rd(4'ha, 8'h45);
		master_on = 1'b0;
		repeat (10) @(negedge clk_sys);
		cmp({2'h0, switch_drive, fault_n, pg_n}, 8'h1f);
		rd(4'ha, 8'h00);
		report_and_stop();
	end
endmodule : hot_swap_power_sequencer_test
`default_nettype wire
